// File: hdl/lowvolt_and_ram_backup_control.sv
`timescale 1ns/1ns
`default_nettype none
module lowvolt_and_ram_backup_control #(
  parameter int SETTLE_CYCLES = pm_pkg::OSC_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        belowIrqLevel,
  input  wire logic        belowRstLevel,
  input  wire logic        coldResetReq,
  input  wire logic [3:0]  port0Pins,
  input  wire logic [3:0]  port1Pins,
  input  wire logic [1:0]  port2Pins,
  input  wire logic        keyPin,
  input  wire logic [1:0]  extIrqPins,
  output var  logic        lowvoltIrq,
  output var  logic        sysReset,
  output var  logic        oscEnable,
  output var  logic        resetPinDriveLow,
  output var  logic        coreInit,
  output var  logic [2:0]  stackLevelInit,
  output var  logic        counterPinLow,
  output var  logic        portHold,
  output var  logic [1:0]  extFlagSuppress,
  output var  logic        powerDownFlag
);
  pm_if pm ();

  pm_pkg::state_t state;
  pm_pkg::state_t next_state;
  logic [3:0]  port0WakeEn;
  logic [3:0]  port1WakeEn;
  logic [3:0]  port2KeyWakeEn;
  logic [3:0]  extWakeCtl;
  logic [1:0]  extWakePol;
  logic [3:0]  lvIrqSelect;
  logic        armed;
  logic [11:0] settleCount;
  logic        xferDone;
  logic        wrDone;
  logic        instrWr;
  logic        armWr;
  logic        powerOffWr;
  logic        softResetWr;
  logic        enterBackup;
  logic        coldEvent;
  logic [31:0] next_rdata;
  logic        mapped;

  lowvolt_detect u_lvd (
    .clk           (clk),
    .reset         (reset),
    .belowIrqLevel (belowIrqLevel),
    .belowRstLevel (belowRstLevel),
    .pm            (pm.lvd)
  );

  wake_detect #(.KEYS(11)) u_wake (
    .clk     (clk),
    .reset   (reset),
    .keyPins ({keyPin, port2Pins, port1Pins, port0Pins}),
    .extPins (extIrqPins),
    .pm      (pm.wkd)
  );

  assign pm.backup = (state == pm_pkg::BACKUP);
  assign pm.keyEn  = {port2KeyWakeEn[2:0], port1WakeEn, port0WakeEn};
  assign pm.extCtl = extWakeCtl;
  assign pm.extPol = extWakePol;

  // one wait state so read data can come straight from a flop
  assign xferDone    = psel && penable && pready;
  assign wrDone      = xferDone && pwrite && !pslverr && state == pm_pkg::RUN;
  assign instrWr     = wrDone && paddr == pm_pkg::OFF_INSTR;
  assign armWr       = instrWr && pwdata[1:0] == pm_pkg::OP_ARM;
  assign powerOffWr  = instrWr && pwdata[1:0] == pm_pkg::OP_POWEROFF;
  assign softResetWr = instrWr && pwdata[1:0] == pm_pkg::OP_SOFTRESET;
  assign enterBackup = powerOffWr && armed;
  assign coldEvent   = coldResetReq || softResetWr;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      pm_pkg::OFF_INSTR: next_rdata = 32'h0000_0000;
      pm_pkg::OFF_STATUS: begin
        next_rdata[pm_pkg::ST_LVFLAG] = pm.lvFlag;
        next_rdata[pm_pkg::ST_PDFLAG] = powerDownFlag;
        next_rdata[pm_pkg::ST_ARMED]  = armed;
        next_rdata[pm_pkg::ST_BACKUP] = pm.backup;
      end
      pm_pkg::OFF_LVSEL:  next_rdata[3:0] = lvIrqSelect;
      pm_pkg::OFF_WAKE0:  next_rdata[3:0] = port0WakeEn;
      pm_pkg::OFF_WAKE1:  next_rdata[3:0] = port1WakeEn;
      pm_pkg::OFF_WAKE2:  next_rdata[3:0] = port2KeyWakeEn;
      pm_pkg::OFF_EXTCTL: next_rdata[3:0] = extWakeCtl;
      pm_pkg::OFF_EXTPOL: next_rdata[1:0] = extWakePol;
      default:            mapped = 1'b0;
    endcase
  end

  // pready is a flop, so every access costs exactly one wait state
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // prdata holds between reads; writes return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end
  end

  // arm survives exactly one instruction; any other completed access drops it
  always_ff @(posedge clk) begin
    if (reset || state != pm_pkg::RUN) begin
      armed <= 1'b0;
    end else if (xferDone) begin
      armed <= armWr;
    end
  end

  // wake enables cleared only by reset, cold events or low-supply reset, never by back-up entry
  always_ff @(posedge clk) begin
    if (reset || coldEvent || state == pm_pkg::LVRESET) begin
      port0WakeEn    <= pm_pkg::NIBBLE_RST;
      port1WakeEn    <= pm_pkg::NIBBLE_RST;
      port2KeyWakeEn <= pm_pkg::NIBBLE_RST;
      extWakeCtl     <= pm_pkg::NIBBLE_RST;
      extWakePol     <= pm_pkg::EXTPOL_RST;
    end else if (wrDone) begin
      unique case (paddr)
        pm_pkg::OFF_WAKE0:  port0WakeEn    <= pwdata[3:0];
        pm_pkg::OFF_WAKE1:  port1WakeEn    <= pwdata[3:0];
        pm_pkg::OFF_WAKE2:  port2KeyWakeEn <= pwdata[3:0];
        pm_pkg::OFF_EXTCTL: extWakeCtl     <= pwdata[3:0];
        pm_pkg::OFF_EXTPOL: extWakePol     <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // selection register is not retained across back-up
  always_ff @(posedge clk) begin
    if (reset || coldEvent || state != pm_pkg::RUN || enterBackup) begin
      lvIrqSelect <= pm_pkg::NIBBLE_RST;
    end else if (wrDone && paddr == pm_pkg::OFF_LVSEL) begin
      lvIrqSelect <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lowvoltIrq <= 1'b0;
    end else begin
      lowvoltIrq <= pm.lvFlag && lvIrqSelect[pm_pkg::LVSEL_IRQ];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      pm_pkg::RUN: begin
        if (coldEvent) begin
          next_state = pm_pkg::COLD;
        end else if (pm.lvReset) begin
          next_state = pm_pkg::LVRESET;
        end else if (enterBackup) begin
          next_state = pm_pkg::BACKUP;
        end
      end
      pm_pkg::BACKUP: begin
        if (coldResetReq) begin
          next_state = pm_pkg::COLD;
        end else if (pm.wakeHit) begin
          next_state = pm_pkg::SETTLE;
        end
      end
      pm_pkg::LVRESET: begin
        if (coldResetReq) begin
          next_state = pm_pkg::COLD;
        end else if (!pm.lvReset) begin
          next_state = pm_pkg::SETTLE;
        end
      end
      pm_pkg::COLD: next_state = pm_pkg::RUN;
      // a supply drop while settling must still win over the restart
      pm_pkg::SETTLE: begin
        if (coldResetReq) begin
          next_state = pm_pkg::COLD;
        end else if (pm.lvReset) begin
          next_state = pm_pkg::LVRESET;
        end else if (settleCount == 12'(SETTLE_CYCLES - 1)) begin
          next_state = pm_pkg::RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= pm_pkg::COLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state != pm_pkg::SETTLE) begin
      settleCount <= 12'h000;
    end else begin
      settleCount <= settleCount + 12'h001;
    end
  end

  // warm start leaves the flag at one until the next cold event or low-supply reset
  always_ff @(posedge clk) begin
    if (reset || coldEvent || state == pm_pkg::LVRESET) begin
      powerDownFlag <= 1'b0;
    end else if (state == pm_pkg::BACKUP && pm.wakeHit) begin
      powerDownFlag <= 1'b1;
    end
  end

  // the core restarts from page 0 address 0 whenever sysReset falls
  always_ff @(posedge clk) begin
    if (reset) begin
      sysReset <= 1'b1;
    end else begin
      sysReset <= next_state != pm_pkg::RUN;
    end
  end

  // oscillator comes back in settle, one state before the reset is let go
  always_ff @(posedge clk) begin
    if (reset) begin
      oscEnable <= 1'b1;
    end else begin
      oscEnable <= next_state != pm_pkg::LVRESET && next_state != pm_pkg::BACKUP;
    end
  end

  // only the soft reset instruction pulls the reset pin; supply resets never do
  always_ff @(posedge clk) begin
    if (reset) begin
      resetPinDriveLow <= 1'b0;
    end else begin
      resetPinDriveLow <= softResetWr;
    end
  end

  // timers and unlisted state are left to the core and may be undefined
  always_ff @(posedge clk) begin
    if (reset) begin
      coreInit <= 1'b0;
    end else begin
      coreInit <= enterBackup;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stackLevelInit <= pm_pkg::SP_INIT;
    end else begin
      stackLevelInit <= pm_pkg::SP_INIT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      counterPinLow <= 1'b0;
    end else begin
      counterPinLow <= next_state == pm_pkg::BACKUP;
    end
  end

  // port latches live in the core; this only freezes them
  always_ff @(posedge clk) begin
    if (reset) begin
      portHold <= 1'b0;
    end else begin
      portHold <= next_state == pm_pkg::BACKUP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      extFlagSuppress <= 2'h0;
    end else if (state == pm_pkg::BACKUP && pm.wakeHit) begin
      extFlagSuppress <= pm.levelWake;
    end else if (next_state == pm_pkg::RUN) begin
      extFlagSuppress <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pm_pkg.sv
package pm_pkg;
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LVSEL  = 8'h08;
  localparam logic [7:0] OFF_WAKE0  = 8'h0C;
  localparam logic [7:0] OFF_WAKE1  = 8'h10;
  localparam logic [7:0] OFF_WAKE2  = 8'h14;
  localparam logic [7:0] OFF_EXTCTL = 8'h18;
  localparam logic [7:0] OFF_EXTPOL = 8'h1C;

  localparam logic [1:0] OP_OTHER     = 2'h0;
  localparam logic [1:0] OP_ARM       = 2'h1;
  localparam logic [1:0] OP_POWEROFF  = 2'h2;
  localparam logic [1:0] OP_SOFTRESET = 2'h3;

  localparam logic [3:0] NIBBLE_RST  = 4'h0;
  localparam logic [1:0] EXTPOL_RST  = 2'h0;
  localparam int         LVSEL_IRQ   = 0;
  localparam int         ST_LVFLAG   = 0;
  localparam int         ST_PDFLAG   = 1;
  localparam int         ST_ARMED    = 2;
  localparam int         ST_BACKUP   = 3;
  localparam int         EXT_EN      = 0;
  localparam int         EXT_LEVEL   = 1;
  localparam logic [2:0] SP_INIT     = 3'h7;

  localparam int CLK_PERIOD_NS   = 10;
  localparam int OSC_SETTLE_NS   = 2000;
  localparam int OSC_SETTLE_CYC  = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {RUN, BACKUP, LVRESET, COLD, SETTLE} state_t;
endpackage

// File: hdl/pm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pm_if;
  logic        backup;
  logic        lvFlag;
  logic        lvReset;
  logic [10:0] keyEn;
  logic [3:0]  extCtl;
  logic [1:0]  extPol;
  logic        wakeHit;
  logic [1:0]  levelWake;
  modport lvd (input backup, output lvFlag, lvReset);
  modport wkd (input backup, keyEn, extCtl, extPol, output wakeHit, levelWake);
  modport ctl (output backup, keyEn, extCtl, extPol, input lvFlag, lvReset, wakeHit, levelWake);
endinterface
`default_nettype wire

// File: hdl/lowvolt_detect.sv
`timescale 1ns/1ns
`default_nettype none
module lowvolt_detect (
  input wire logic clk,
  input wire logic reset,
  input wire logic belowIrqLevel,
  input wire logic belowRstLevel,
  pm_if.lvd        pm
);
  // flag is a plain copy of the comparator, forced low in reset and back-up; no register write clears it
  always_ff @(posedge clk) begin
    if (reset || pm.backup) begin
      pm.lvFlag <= 1'b0;
    end else begin
      pm.lvFlag <= belowIrqLevel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || pm.backup) begin
      pm.lvReset <= 1'b0;
    end else begin
      pm.lvReset <= belowRstLevel;
    end
  end
endmodule
`default_nettype wire

// File: hdl/wake_detect.sv
`timescale 1ns/1ns
`default_nettype none
module wake_detect #(
  parameter int KEYS = 11
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic [KEYS-1:0] keyPins,
  input wire logic [1:0]      extPins,
  pm_if.wkd                   pm
);
  logic [KEYS-1:0] keyPrev;
  logic [1:0]      extPrev;
  logic [KEYS-1:0] keyFall;
  logic [1:0]      extHit;
  logic [1:0]      extLvl;

  always_ff @(posedge clk) begin
    if (reset) begin
      keyPrev <= '1;
      extPrev <= 2'h0;
    end else begin
      keyPrev <= keyPins;
      extPrev <= extPins;
    end
  end

  genvar i;
  generate
    for (i = 0; i < KEYS; i++) begin : g_key
      assign keyFall[i] = pm.keyEn[i] && keyPrev[i] && !keyPins[i];
    end
    for (i = 0; i < 2; i++) begin : g_ext
      // polarity 1 selects high level or rising edge
      assign extLvl[i] = pm.extCtl[2*i+pm_pkg::EXT_EN] && pm.extCtl[2*i+pm_pkg::EXT_LEVEL]
                         && (extPins[i] == pm.extPol[i]);
      assign extHit[i] = extLvl[i] || (pm.extCtl[2*i+pm_pkg::EXT_EN]
                         && !pm.extCtl[2*i+pm_pkg::EXT_LEVEL]
                         && extPrev[i] != extPins[i] && extPins[i] == pm.extPol[i]);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset || !pm.backup) begin
      pm.wakeHit   <= 1'b0;
      pm.levelWake <= 2'h0;
    end else begin
      pm.wakeHit   <= |keyFall || |extHit;
      pm.levelWake <= extLvl;
    end
  end
endmodule
`default_nettype wire

// File: bench/supply_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
module supply_pins_model (
  input  wire logic       clk,
  output var  logic       belowIrqLevel,
  output var  logic       belowRstLevel,
  output var  logic [3:0] port0Pins,
  output var  logic [3:0] port1Pins,
  output var  logic [1:0] port2Pins,
  output var  logic       keyPin,
  output var  logic [1:0] extIrqPins
);
  // key pins sit on pull-ups, so an idle key reads high
  initial begin
    belowIrqLevel = 1'b0;
    belowRstLevel = 1'b0;
    port0Pins = 4'hF;
    port1Pins = 4'hF;
    port2Pins = 2'h3;
    keyPin = 1'b1;
    extIrqPins = 2'h0;
  end
  task automatic supply(input logic irq, input logic rst);
    @(posedge clk);
    belowIrqLevel <= irq;
    belowRstLevel <= rst;
  endtask
  // a key press is a high-to-low edge on a pulled-up pin
  task automatic press(input logic [3:0] p0, input logic [1:0] ext);
    @(posedge clk);
    port0Pins <= p0;
    extIrqPins <= ext;
  endtask
endmodule
`default_nettype wire

// File: bench/pm_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pm_sva #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        belowIrqLevel,
  input wire logic        belowRstLevel,
  input wire logic        coldResetReq,
  input wire logic        lowvoltIrq,
  input wire logic        sysReset,
  input wire logic        oscEnable,
  input wire logic        resetPinDriveLow,
  input wire logic        coreInit,
  input wire logic [2:0]  stackLevelInit,
  input wire logic        counterPinLow,
  input wire logic        portHold,
  input wire logic        powerDownFlag
);
  localparam int SETTLE_MAX = SETTLE_CYCLES + 4;
  logic armed;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // arm only counts while running; an arm taken in reset would be ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (psel && penable && pready) begin
      armed <= pwrite && !sysReset && paddr == pm_pkg::OFF_INSTR
               && pwdata[1:0] == pm_pkg::OP_ARM;
    end
  end
  sequence s_off;
    psel && penable && pready && pwrite && paddr == pm_pkg::OFF_INSTR
      && pwdata[1:0] == pm_pkg::OP_POWEROFF;
  endsequence
  sequence s_release(w);
    oscEnable && sysReset ##[1:SETTLE_MAX] (!sysReset && powerDownFlag == w);
  endsequence
  // flag takes one flop and the interrupt output a second one
  property p_track; lowvoltIrq |-> $past(belowIrqLevel, 2); endproperty
  property p_quiet; portHold |-> !lowvoltIrq; endproperty
  property p_lvHold;
    belowRstLevel && !portHold && !coldResetReq |-> ##2 (!oscEnable && sysReset);
  endproperty
  property p_noPin; !oscEnable |-> !resetPinDriveLow; endproperty
  property p_lvRelease;
    !oscEnable && !portHold && !belowRstLevel && !coldResetReq |-> ##2 s_release(1'b0);
  endproperty
  property p_entry; s_off ##0 (armed && !sysReset) |=> portHold && coreInit; endproperty
  property p_noEntry; s_off ##0 (!armed && !portHold) |=> !portHold; endproperty
  property p_backup;
    $rose(portHold) |-> !oscEnable && sysReset && counterPinLow
      && stackLevelInit == pm_pkg::SP_INIT;
  endproperty
  property p_warm; $fell(portHold) |-> s_release(1'b1); endproperty
  property p_cold; coldResetReq |-> ##[1:2] (sysReset && !powerDownFlag); endproperty
  a_track: assert property (p_track) else $error("flag not following comparator");
  a_quiet: assert property (p_quiet) else $error("flag active in back-up");
  a_lvHold: assert property (p_lvHold) else $error("low supply reset missing");
  a_noPin: assert property (p_noPin) else $error("reset pin driven in lv reset");
  a_lvRelease: assert property (p_lvRelease) else $error("lv reset release wrong");
  a_entry: assert property (p_entry) else $error("back-up not entered");
  a_noEntry: assert property (p_noEntry) else $error("unarmed power-off acted");
  a_backup: assert property (p_backup) else $error("back-up outputs wrong");
  a_warm: assert property (p_warm) else $error("warm start wrong");
  a_cold: assert property (p_cold) else $error("cold start flag wrong");
endmodule
bind lowvolt_and_ram_backup_control pm_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk (
  .clk              (clk),
  .reset            (reset),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .pready           (pready),
  .belowIrqLevel    (belowIrqLevel),
  .belowRstLevel    (belowRstLevel),
  .coldResetReq     (coldResetReq),
  .lowvoltIrq       (lowvoltIrq),
  .sysReset         (sysReset),
  .oscEnable        (oscEnable),
  .resetPinDriveLow (resetPinDriveLow),
  .coreInit         (coreInit),
  .stackLevelInit   (stackLevelInit),
  .counterPinLow    (counterPinLow),
  .portHold         (portHold),
  .powerDownFlag    (powerDownFlag)
);
`default_nettype wire

// File: bench/test_lowvolt_and_ram_backup_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_lowvolt_and_ram_backup_control;
  localparam int SETTLE = 4;
  logic        clk = 1'b0;
  logic        reset, psel, penable, pwrite, coldResetReq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, belowIrqLevel, belowRstLevel, keyPin;
  logic [3:0]  port0Pins, port1Pins;
  logic [1:0]  port2Pins, extIrqPins, extFlagSuppress;
  logic        lowvoltIrq, sysReset, oscEnable, resetPinDriveLow, coreInit;
  logic        counterPinLow, portHold, powerDownFlag;
  logic [2:0]  stackLevelInit;
  int          errors = 0, num_checks = 0, pinPulses = 0;
  lowvolt_and_ram_backup_control #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk              (clk),
    .reset            (reset),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .belowIrqLevel    (belowIrqLevel),
    .belowRstLevel    (belowRstLevel),
    .coldResetReq     (coldResetReq),
    .port0Pins        (port0Pins),
    .port1Pins        (port1Pins),
    .port2Pins        (port2Pins),
    .keyPin           (keyPin),
    .extIrqPins       (extIrqPins),
    .lowvoltIrq       (lowvoltIrq),
    .sysReset         (sysReset),
    .oscEnable        (oscEnable),
    .resetPinDriveLow (resetPinDriveLow),
    .coreInit         (coreInit),
    .stackLevelInit   (stackLevelInit),
    .counterPinLow    (counterPinLow),
    .portHold         (portHold),
    .extFlagSuppress  (extFlagSuppress),
    .powerDownFlag    (powerDownFlag)
  );
  supply_pins_model env (
    .clk           (clk),
    .belowIrqLevel (belowIrqLevel),
    .belowRstLevel (belowRstLevel),
    .port0Pins     (port0Pins),
    .port1Pins     (port1Pins),
    .port2Pins     (port2Pins),
    .keyPin        (keyPin),
    .extIrqPins    (extIrqPins)
  );
  always #5 clk = ~clk;
  always @(posedge clk) if (resetPinDriveLow === 1'b1) pinPulses++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic instr(input logic [1:0] op);
    apb(1'b1, pm_pkg::OFF_INSTR, {30'h0, op});
  endtask
  task automatic waitRun();
    for (int n = 0; n < 50 && sysReset !== 1'b0; n++) @(posedge clk);
    check("running", sysReset, 1'b0);
  endtask
  task automatic enterBackup();
    instr(pm_pkg::OP_OTHER);
    instr(pm_pkg::OP_ARM);
    instr(pm_pkg::OP_POWEROFF);
    repeat (2) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    coldResetReq = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk("status cold", pm_pkg::OFF_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdchk("wake reset", pm_pkg::OFF_WAKE0 + 8'(4 * i), 32'h0);
      apb(1'b1, pm_pkg::OFF_WAKE0 + 8'(4 * i), 32'hF);
      rdchk("wake rw", pm_pkg::OFF_WAKE0 + 8'(4 * i), 32'hF);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", err, 1'b1);
    $display("test registers done");
    apb(1'b1, pm_pkg::OFF_LVSEL, 32'h1);
    env.supply(1'b1, 1'b0);
    rdchk("lv set", pm_pkg::OFF_STATUS, 32'h1);
    rdchk("lv kept", pm_pkg::OFF_STATUS, 32'h1);
    check("lv irq", lowvoltIrq, 1'b1);
    apb(1'b1, pm_pkg::OFF_LVSEL, 32'h0);
    repeat (2) @(posedge clk);
    check("lv skip use", lowvoltIrq, 1'b0);
    env.supply(1'b0, 1'b0);
    rdchk("lv clear", pm_pkg::OFF_STATUS, 32'h0);
    $display("test lowvolt flag done");
    instr(pm_pkg::OP_POWEROFF);
    instr(pm_pkg::OP_ARM);
    rdchk("armed", pm_pkg::OFF_STATUS, 32'h4);
    instr(pm_pkg::OP_POWEROFF);
    rdchk("no backup", pm_pkg::OFF_STATUS, 32'h0);
    $display("test unarmed done");
    for (int i = 1; i < 4; i++) apb(1'b1, pm_pkg::OFF_WAKE0 + 8'(4 * i), 32'h0);
    apb(1'b1, pm_pkg::OFF_WAKE0, 32'h2);
    apb(1'b1, pm_pkg::OFF_LVSEL, 32'h1);
    enterBackup();
    check("hold", portHold, 1'b1);
    check("counter pin", counterPinLow, 1'b1);
    check("osc off", oscEnable, 1'b0);
    check("stack", stackLevelInit, pm_pkg::SP_INIT);
    env.supply(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    check("lv off", lowvoltIrq, 1'b0);
    env.supply(1'b0, 1'b0);
    env.press(4'hE, 2'h0);
    repeat (4) @(posedge clk);
    check("disabled key", portHold, 1'b1);
    env.press(4'hC, 2'h0);
    waitRun();
    rdchk("warm", pm_pkg::OFF_STATUS, 32'h2);
    rdchk("wake kept", pm_pkg::OFF_WAKE0, 32'h2);
    rdchk("sel init", pm_pkg::OFF_LVSEL, 32'h0);
    env.press(4'hF, 2'h0);
    coldResetReq <= 1'b1;
    @(posedge clk);
    coldResetReq <= 1'b0;
    @(posedge clk);
    check("cold held", sysReset, 1'b1);
    waitRun();
    rdchk("cold", pm_pkg::OFF_STATUS, 32'h0);
    rdchk("wake cleared", pm_pkg::OFF_WAKE0, 32'h0);
    $display("test key wakeup done");
    apb(1'b1, pm_pkg::OFF_EXTCTL, 32'hC);
    apb(1'b1, pm_pkg::OFF_EXTPOL, 32'h2);
    enterBackup();
    check("ext hold", portHold, 1'b1);
    env.press(4'hF, 2'h2);
    for (int n = 0; n < 20 && portHold === 1'b1; n++) @(posedge clk);
    check("level flag", extFlagSuppress, 2'h2);
    waitRun();
    env.press(4'hF, 2'h0);
    $display("test level wakeup done");
    check("no pin pulse", pinPulses, 0);
    env.supply(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    check("lv osc", oscEnable, 1'b0);
    check("lv reset", sysReset, 1'b1);
    env.supply(1'b0, 1'b0);
    waitRun();
    rdchk("lv cold", pm_pkg::OFF_STATUS, 32'h0);
    check("no pin pulse", pinPulses, 0);
    instr(pm_pkg::OP_SOFTRESET);
    waitRun();
    check("pin pulse", pinPulses, 1);
    rdchk("soft cold", pm_pkg::OFF_STATUS, 32'h0);
    $display("test resets done");
    wrap_up();
  end
endmodule
`default_nettype wire
